// [logic/mpt_pkg.sv]
// shared constants and state types of the match based pulse timer
package mpt_pkg;
   localparam int unsigned MPT_NUM_MATCH = 7;
   localparam int unsigned MPT_NUM_OUT   = 6;
   localparam int unsigned MPT_WIDTH     = 32;
   // match control field positions
   localparam int unsigned MPT_CTL_IRQ   = 0;
   localparam int unsigned MPT_CTL_RESET = 1;
   localparam int unsigned MPT_CTL_STOP  = 2;
   localparam int unsigned MPT_CTL_W     = 3;
   // values after reset, and the count increment
   localparam logic [31:0] MPT_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] MPT_MATCH_RST = 32'h0000_0000;
   localparam logic [31:0] MPT_ONE       = 32'h0000_0001;

   typedef struct packed {
      logic [31:0] count;
   } mpt_pre_state_t;

   typedef struct packed {
      logic [31:0]       count;
      logic              stopped;
      logic [6:0][31:0]  active;
      logic [6:0][31:0]  staged;
      logic [6:0]        pending;
      logic [5:0]        pwm;
      logic [6:0]        hit;
      logic [6:0]        irq;
   } mpt_state_t;
endpackage : mpt_pkg

// [logic/mpt_tick_if.sv]
// prescaler control and tick between the timer core and its prescaler
`timescale 1ns/1ns
interface mpt_tick_if;
   logic        run;
   logic        clear;
   logic [31:0] limit;
   logic        tick;
   logic [31:0] count;

   modport ctrl (output run, output clear, output limit, input tick, input count);
   modport pre  (input run, input clear, input limit, output tick, output count);
endinterface : mpt_tick_if

// [logic/mpt_prescaler.sv]
// programmable 32-bit prescaler producing the timer count tick
`timescale 1ns/1ns
module mpt_prescaler
   import mpt_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_b,
   mpt_tick_if.pre   tk
);
   mpt_pre_state_t st;
   mpt_pre_state_t next_st;

   // tick is combinational so the counter advances in the same cycle the limit is hit
   assign tk.tick  = tk.run && !tk.clear && (st.count == tk.limit);
   assign tk.count = st.count;

   // wrap to zero at the limit
   always_comb
   begin
      next_st = st;
      if (tk.clear)
         next_st.count = MPT_COUNT_RST;
      else if (tk.tick)
         next_st.count = MPT_COUNT_RST;
      else if (tk.run)
         next_st.count = st.count + MPT_ONE;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         st <= '{count: MPT_COUNT_RST};
      else
         st <= next_st;
   end
endmodule : mpt_prescaler

// [logic/mpt_top.sv]
// match based pulse width timer: counter, seven shadowed matches, six outputs
// Behaviour
// - a 32-bit timer count advances through a programmable 32-bit prescaler.
// - the count is compared with seven match values that raise events and output actions.
// - in modulation mode a match on the period match value clears the count, giving one common output period.
// - a single-edge output rises on the period match and falls on its own match.
// - a single-edge output whose match value is zero stays low, except in count 0 of the period its zero lands in, which follows the old value.
// - a double-edge output rises on one match and falls on the next, either order allowed.
// - up to six single-edge, five double-edge (outputs 1 to 5) or a mix of outputs are supported.
// - each match may raise an event and may keep counting, stop or clear the counter.
// - period and pulse width are any whole number of counts.
// - new match values take effect in step with the outputs, except that the single-edge rise at the period match follows the old value.
// - with modulation off the block is a plain match timer and outputs stay low.
`timescale 1ns/1ns
module mpt_top
   import mpt_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              counter_enable,
   input  wire logic              counter_clear,
   input  wire logic              pwm_mode,
   input  wire logic [31:0]       prescale_limit,
   input  wire logic [6:0][31:0]  match_value,
   input  wire logic [6:0]        match_release,
   input  wire logic [6:0][2:0]   match_control,
   input  wire logic [5:0]        double_edge,
   input  wire logic [5:0]        output_enable,
   output logic      [5:0]        pwm_out,
   output logic      [31:0]       timer_count,
   output logic      [31:0]       prescale_count,
   output logic                   counter_stopped,
   output logic      [6:0]        match_event,
   output logic      [6:0]        match_irq
);
   mpt_state_t  st;
   mpt_state_t  next_st;
   mpt_tick_if  tk ();

   logic [6:0]  hit_now;
   logic [6:0]  irq_sel;
   logic [6:0]  stop_sel;
   logic [6:0]  reset_sel;
   logic [5:0]  next_pwm;
   logic        reset_hit;
   logic        apply;

   mpt_prescaler mpt_prescaler_i (
      .clock (clock),
      .rst_b (rst_b),
      .tk    (tk)
   );

   // prescaler runs only while the counter is allowed to count
   assign tk.run   = counter_enable && !st.stopped;
   assign tk.clear = counter_clear;
   assign tk.limit = prescale_limit;

   // per match compare against the active (released) copy
   genvar gi;
   generate
      for (gi = 0; gi < MPT_NUM_MATCH; gi++)
      begin : g_match
         assign hit_now[gi]   = tk.tick && (st.count == st.active[gi]);
         assign irq_sel[gi]   = match_control[gi][MPT_CTL_IRQ];
         assign stop_sel[gi]  = match_control[gi][MPT_CTL_STOP];
         assign reset_sel[gi] = match_control[gi][MPT_CTL_RESET];
      end
   endgenerate

   // period match always clears in modulation mode, whatever its control bits
   assign reset_hit = |(hit_now & reset_sel) || (pwm_mode && hit_now[0]);
   // in modulation mode shadow copies land at the cycle boundary so no edge is cut short; in timer mode they land at once
   assign apply     = pwm_mode ? hit_now[0] : 1'b1;

   // output edge logic, one instance per output; output 0 is single-edge only
   genvar go;
   generate
      for (go = 0; go < MPT_NUM_OUT; go++)
      begin : g_out
         logic dbl;
         logic rise;
         logic fall;
         assign dbl  = (go != 0) && double_edge[go];
         // a zero match would rise and fall in the same count, so it holds low
         assign rise = dbl ? hit_now[go]
                           : (hit_now[0] && (st.active[go + 1] != MPT_MATCH_RST));
         assign fall = hit_now[go + 1];
         always_comb
         begin
            if (!pwm_mode || !output_enable[go])
               next_pwm[go] = 1'b0;
            else if (fall)
               next_pwm[go] = 1'b0;   // fall wins when both land together
            else if (rise)
               next_pwm[go] = 1'b1;
            else
               next_pwm[go] = st.pwm[go];
         end
      end
   endgenerate

   // next state of the whole core
   always_comb
   begin
      next_st     = st;
      next_st.hit = hit_now;
      next_st.irq = hit_now & irq_sel;
      next_st.pwm = next_pwm;
      // a release in the apply cycle stays pending: the set wins over the clear
      next_st.pending = (st.pending & ~{7{apply}}) | match_release;
      for (int i = 0; i < MPT_NUM_MATCH; i++)
      begin
         if (apply && st.pending[i])
            next_st.active[i] = st.staged[i];
         if (match_release[i])
            next_st.staged[i] = match_value[i];
      end
      if (!counter_enable || counter_clear)
         next_st.stopped = 1'b0;
      else if (|(hit_now & stop_sel))
         next_st.stopped = 1'b1;
      if (counter_clear)
         next_st.count = MPT_COUNT_RST;
      else if (tk.tick && reset_hit)
         next_st.count = MPT_COUNT_RST;
      else if (tk.tick)
         next_st.count = st.count + MPT_ONE;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         st <= '{count: MPT_COUNT_RST, stopped: 1'b0, active: '0, staged: '0,
                 pending: 7'h00, pwm: 6'h00, hit: 7'h00, irq: 7'h00};
      else
         st <= next_st;
   end

   assign pwm_out         = st.pwm;
   assign timer_count     = st.count;
   assign prescale_count  = tk.count;
   assign counter_stopped = st.stopped;
   assign match_event     = st.hit;
   assign match_irq       = st.irq;

   property p_count_step;
      @(posedge clock) disable iff (!rst_b)
      tk.tick && !reset_hit && !counter_clear |=> st.count == $past(st.count) + MPT_ONE;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step");

   property p_period_reset;
      @(posedge clock) disable iff (!rst_b)
      pwm_mode && hit_now[0] |=> st.count == MPT_COUNT_RST;
   endproperty
   a_period_reset: assert property (p_period_reset) else $error("period not cleared");

   property p_single_rise;
      @(posedge clock) disable iff (!rst_b)
      pwm_mode && output_enable[0] && hit_now[0] && !hit_now[1]
         && st.active[1] != MPT_MATCH_RST |=> pwm_out[0];
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("no rise at period");

   property p_single_fall;
      @(posedge clock) disable iff (!rst_b)
      hit_now[1] ##1 1'b1 |-> !pwm_out[0];
   endproperty
   a_single_fall: assert property (p_single_fall) else $error("no fall on match");

   property p_const_low;
      @(posedge clock) disable iff (!rst_b)
      !pwm_out[0] && st.active[1] == MPT_MATCH_RST && st.pending == 7'h00
         |=> !pwm_out[0] [*2];
   endproperty
   a_const_low: assert property (p_const_low) else $error("zero match rose");

   property p_double_rise;
      @(posedge clock) disable iff (!rst_b)
      pwm_mode && output_enable[2] && double_edge[2] && hit_now[2] && !hit_now[3]
         |=> pwm_out[2];
   endproperty
   a_double_rise: assert property (p_double_rise) else $error("double rise lost");

   property p_stop_hold;
      @(posedge clock) disable iff (!rst_b)
      counter_stopped && !counter_clear |=> $stable(timer_count);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped count moved");

   property p_shadow_hold;
      @(posedge clock) disable iff (!rst_b)
      pwm_mode && !hit_now[0] |=> $stable(st.active);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("match changed mid period");

   property p_timer_quiet;
      @(posedge clock) disable iff (!rst_b)
      !pwm_mode |=> pwm_out == 6'h00;
   endproperty
   a_timer_quiet: assert property (p_timer_quiet) else $error("output in timer mode");

   property p_irq_follow;
      @(posedge clock) disable iff (!rst_b)
      hit_now[2] && match_control[2][MPT_CTL_IRQ] |=> match_irq[2] && match_event[2];
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("match event lost");
endmodule : mpt_top

// [sim/tb_mpt_top.sv]
// self-checking bench of the match based pulse timer
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
   begin \
      compares++; \
      if ((got) !== (ex)) \
      begin \
         error_cnt++; \
         $display("Error %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module tb_mpt_top;
   logic             clock;
   logic             rst_b;
   logic             counter_enable;
   logic             counter_clear;
   logic             pwm_mode;
   logic [31:0]      prescale_limit;
   logic [6:0][31:0] match_value;
   logic [6:0]       match_release;
   logic [6:0][2:0]  match_control;
   logic [5:0]       double_edge;
   logic [5:0]       output_enable;
   logic [5:0]       pwm_out;
   logic [31:0]      timer_count;
   logic [31:0]      prescale_count;
   logic             counter_stopped;
   logic [6:0]       match_event;
   logic [6:0]       match_irq;
   logic [31:0]      save;
   logic [5:0]       exp_wave [5];
   int               error_cnt;
   int               compares;
   int               n;

   mpt_top mpt_top_i (.clock(clock), .rst_b(rst_b), .counter_enable(counter_enable),
      .counter_clear(counter_clear), .pwm_mode(pwm_mode), .prescale_limit(prescale_limit),
      .match_value(match_value), .match_release(match_release),
      .match_control(match_control), .double_edge(double_edge),
      .output_enable(output_enable), .pwm_out(pwm_out), .timer_count(timer_count),
      .prescale_count(prescale_count), .counter_stopped(counter_stopped),
      .match_event(match_event), .match_irq(match_irq));

   // inputs move 2 ns after the edge so the design samples settled values
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #2;
   endtask : step

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // bounded wait, a stuck counter ends the run instead of hanging it
   task automatic wait_count(input logic [31:0] v);
      for (int i = 0; i < 200 && timer_count !== v; i++)
         step(1);
      if (timer_count !== v)
      begin
         error_cnt++;
         $display("Error timer_count expected %0h seen %0h", v, timer_count);
         test_done();
      end
   endtask : wait_count

   task automatic release_match(input int i, input logic [31:0] v);
      match_value[i] = v;
      match_release[i] = 1'b1;
      step(1);
      match_release[i] = 1'b0;
   endtask : release_match

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial
   begin
      error_cnt = 0;
      compares = 0;
      rst_b = 1'b0;
      counter_enable = 1'b0;
      counter_clear = 1'b0;
      pwm_mode = 1'b1;
      prescale_limit = 32'h0;
      match_value = '0;
      match_release = '0;
      match_control = '0;
      match_control[0] = 3'h1;
      // match 2 raises its event too, so the event gating is exercised
      match_control[2] = 3'h1;
      double_edge = 6'h14;
      output_enable = 6'h3F;
      // outputs per shown count: singles 0,1,3,5; positive pulse 2; negative pulse 4
      exp_wave = '{6'h1B, 6'h1B, 6'h0D, 6'h0C, 6'h10};
      step(3);
      rst_b = 1'b1;
      `CHK("pwm_out reset", 6'h00, pwm_out)
      release_match(0, 32'h4);
      release_match(1, 32'h2);
      release_match(2, 32'h1);
      release_match(3, 32'h3);
      release_match(4, 32'h3);
      release_match(5, 32'h1);
      counter_enable = 1'b1;
      wait_count(32'h4);
      for (n = 0; n < 10; n++)
      begin
         step(1);
         `CHK("timer_count", 32'(n % 5), timer_count)
         `CHK("pwm_out", exp_wave[n % 5], pwm_out)
         `CHK("match_irq0", (n % 5 == 0), match_irq[0])
         `CHK("match_event1", (n % 5 == 3), match_event[1])
         `CHK("match_irq1 gated", 1'b0, match_irq[1])
      end
      // a shorter width released mid period must wait for the wrap
      wait_count(32'h0);
      release_match(1, 32'h1);
      wait_count(32'h2);
      `CHK("pwm_out0 old width", 1'b1, pwm_out[0])
      wait_count(32'h0);
      wait_count(32'h2);
      `CHK("pwm_out0 new width", 1'b0, pwm_out[0])
      // plain timer mode with a slow prescaler and a stop match
      pwm_mode = 1'b0;
      counter_clear = 1'b1;
      prescale_limit = 32'h2;
      match_control[1] = 3'h4;
      release_match(1, 32'h5);
      counter_clear = 1'b0;
      wait_count(32'h1);
      for (n = 0; n < 10 && timer_count === 32'h1; n++)
         step(1);
      `CHK("prescale cycles", 32'h3, 32'(n))
      `CHK("prescale_count wrap", 32'h0, prescale_count)
      `CHK("pwm_out timer mode", 6'h00, pwm_out)
      wait_count(32'h5);
      step(4);
      `CHK("stopped", 1'b1, counter_stopped)
      save = timer_count;
      step(6);
      `CHK("count frozen", save, timer_count)
      // reset-on-match with its event gated to the irq
      counter_enable = 1'b0;
      counter_clear = 1'b1;
      step(1);
      `CHK("stop cleared", 1'b0, counter_stopped)
      counter_clear = 1'b0;
      match_control[1] = 3'h3;
      counter_enable = 1'b1;
      for (n = 0; n < 40 && match_irq[1] !== 1'b1; n++)
         step(1);
      `CHK("match_irq1", 1'b1, match_irq[1])
      `CHK("match_event1 reset", 1'b1, match_event[1])
      `CHK("count reset by match", 32'h0, timer_count)
      test_done();
   end
endmodule : tb_mpt_top
